//--- src/bcd_exec_params.svh
/*
 * Register offsets, flag bit positions, reset values and BCD constants
 * for the decimal adjust, increment/decrement and power-down execution block.
 * Assumes it is included by bare name from the design modules and the bench.
 */
`ifndef BCD_EXEC_PARAMS_SVH
`define BCD_EXEC_PARAMS_SVH

// Register byte offsets on the APB slave.
`define REG_ACC_OFS 12'h000
`define REG_FLAGS_OFS 12'h004
`define REG_STATUS_OFS 12'h008
`define MEM_BASE_OFS 12'h040

// Flag register bit positions.
`define FLAG_OVF_BIT 0
`define FLAG_NIB_BIT 1
`define FLAG_NULL_BIT 2
`define FLAG_TMO_BIT 3
`define FLAG_PDF_BIT 4
`define FLAG_WIDTH 5

// Reset values.
`define ACC_RESET 8'h00
`define FLAGS_RESET 5'h00
`define MEM_RESET 8'h00

// Decimal adjust constants.
`define BCD_NIBBLE_MAX 4'h9
`define BCD_ADJ_NONE 8'h00
`define BCD_ADJ_LO 8'h06
`define BCD_ADJ_HI 8'h60
`define BCD_ADJ_BOTH 8'h66

`endif

//--- src/bcd_exec_pkg.sv
/*
 * Types shared by the execution block and its arithmetic unit.
 * Assumes the decoder hands over one operation with a data memory address.
 */
package bcd_exec_pkg;

    typedef enum logic [2:0] {
        OP_BCD_ADJUST,
        OP_SUB_ONE_STORE,
        OP_SUB_ONE_TO_ACC,
        OP_ADD_ONE_STORE,
        OP_ADD_ONE_TO_ACC,
        OP_INVERT_TO_ACC,
        OP_POWER_DOWN
    } exec_op_t;

    typedef struct packed {
        exec_op_t op;
        logic [7:0] addr;
    } exec_req_t;

    typedef struct packed {
        logic power_down_flag;
        logic timeout_flag;
        logic result_null_flag;
        logic nibble_overflow_bit;
        logic overflow_out_bit;
    } flags_t;

    typedef struct packed {
        logic [7:0] result;
        logic acc_we;
        logic mem_we;
        logic null_we;
        logic ovf_we;
        logic ovf;
        logic halt;
    } alu_out_t;

endpackage : bcd_exec_pkg

//--- src/bcd_exec_alu.sv
/*
 * Combinational arithmetic for one executed operation.
 * Assumes the caller supplies the addressed memory byte, the accumulator
 * and the carry flags, and applies the write enables it returns.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bcd_exec_params.svh"

module bcd_exec_alu
    import bcd_exec_pkg::*;
(
    // Operation
    input wire exec_op_t op,
    // Operands
    input wire logic [7:0] mem_byte,
    input wire logic [7:0] acc,
    input wire logic ovf,
    input wire logic nib,
    // Result
    output alu_out_t res
);

    logic lo_adj;
    logic hi_adj;
    logic [7:0] adj;
    logic [8:0] sum;

    always_comb begin
        lo_adj = (acc[3:0] > `BCD_NIBBLE_MAX) || nib;
        hi_adj = (acc[7:4] > `BCD_NIBBLE_MAX) || ovf;
        case ({hi_adj, lo_adj})
            2'b01: adj = `BCD_ADJ_LO;
            2'b10: adj = `BCD_ADJ_HI;
            2'b11: adj = `BCD_ADJ_BOTH;
            default: adj = `BCD_ADJ_NONE;
        endcase
        sum = {1'b0, acc} + {1'b0, adj};
        res = '0;
        case (op)
            OP_BCD_ADJUST: begin
                res.result = sum[7:0];
                res.mem_we = 1'b1;
                res.ovf_we = 1'b1;
                res.ovf = ovf | sum[8];
            end
            OP_SUB_ONE_STORE: begin
                res.result = mem_byte - 8'h01;
                res.mem_we = 1'b1;
                res.null_we = 1'b1;
            end
            OP_SUB_ONE_TO_ACC: begin
                res.result = mem_byte - 8'h01;
                res.acc_we = 1'b1;
                res.null_we = 1'b1;
            end
            OP_ADD_ONE_STORE: begin
                res.result = mem_byte + 8'h01;
                res.mem_we = 1'b1;
                res.null_we = 1'b1;
            end
            OP_ADD_ONE_TO_ACC: begin
                res.result = mem_byte + 8'h01;
                res.acc_we = 1'b1;
                res.null_we = 1'b1;
            end
            OP_INVERT_TO_ACC: begin
                res.result = ~mem_byte;
                res.acc_we = 1'b1;
                res.null_we = 1'b1;
            end
            OP_POWER_DOWN: begin
                res.halt = 1'b1;
            end
            default: begin
                res = '0;
            end
        endcase
    end

endmodule : bcd_exec_alu

`default_nettype wire

//--- src/bcd_adjust_incdec_halt_exec.sv
/*
 * Execution stage for decimal adjust, increment, decrement, complement
 * and power-down, with its own data memory, accumulator and flags behind
 * an APB slave.
 * Assumes the decoder and the APB master share sys_clk and that the wake
 * pin is asynchronous to it.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bcd_exec_params.svh"

// Behaviour
// - Adjust adds 6 to low nibble if above 9 or nibble carry set.
// - Adjust adds 6 to high nibble if above 9 or carry set.
// - Adjust stores accumulator plus 00, 06, 60 or 66 into memory.
// - Adjust changes only the carry flag, set when sum passes 100.
// - Decrement-store writes byte minus one back, updates null flag.
// - Decrement-to-acc loads byte minus one, memory kept, null updated.
// - Increment-store writes byte plus one back, updates null flag.
// - Increment-to-acc loads byte plus one, memory kept.
// - Power-down stops execution, gates clock, keeps memory and accumulator.
// - Power-down pulses wdt_clear for one cycle to clear the watchdog.
// - Power-down sets power-down flag, clears timeout flag, nothing else.
// - Complement-to-acc loads inverted byte, memory kept, null updated.
module bcd_adjust_incdec_halt_exec
    import bcd_exec_pkg::*;
#(
    parameter int MEM_WORDS = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoder handshake
    input wire logic exec_valid,
    input wire exec_req_t exec_req,
    output logic exec_ready,
    output logic exec_done,
    // Power control
    input wire logic wake_pin,
    output logic clk_run,
    output logic wdt_clear
);

    localparam int AW = $clog2(MEM_WORDS);
    localparam logic [11:0] MEM_END = 12'(`MEM_BASE_OFS + 4 * MEM_WORDS);

    typedef struct packed {
        logic [MEM_WORDS-1:0][7:0] mem;
        logic [7:0] acc;
        flags_t flags;
        logic halted;
        logic wdt_clr;
        logic done;
        logic [31:0] rdata;
        logic err;
        logic wake_s1;
        logic wake_s2;
        logic wake_s3;
    } state_t;

    state_t s_q;
    state_t s_d;
    alu_out_t alu;
    logic [AW-1:0] idx;
    logic [AW-1:0] bus_idx;
    logic is_mem;
    logic wr_access;
    logic take;

    assign idx = exec_req.addr[AW-1:0];
    assign bus_idx = paddr[AW+1:2];
    assign is_mem = (paddr >= `MEM_BASE_OFS) && (paddr < MEM_END) && (paddr[1:0] == 2'b00);
    assign wr_access = psel && penable && pwrite;
    // A bus write in flight stalls the decoder so the two never collide.
    // No execution while halted.
    assign exec_ready = !s_q.halted && !wr_access;
    assign take = exec_valid && exec_ready;

    assign pready = 1'b1;
    assign prdata = s_q.rdata;
    assign pslverr = s_q.err;
    assign clk_run = !s_q.halted;
    assign wdt_clear = s_q.wdt_clr;
    assign exec_done = s_q.done;

    bcd_exec_alu u_alu (
        .op(exec_req.op),
        .mem_byte(s_q.mem[idx]),
        .acc(s_q.acc),
        .ovf(s_q.flags.overflow_out_bit),
        .nib(s_q.flags.nibble_overflow_bit),
        .res(alu)
    );

    always_comb begin
        s_d = s_q;
        s_d.wdt_clr = 1'b0;
        s_d.done = 1'b0;
        s_d.wake_s1 = wake_pin;
        s_d.wake_s2 = s_q.wake_s1;
        s_d.wake_s3 = s_q.wake_s2;
        if (s_q.halted && s_q.wake_s2 && !s_q.wake_s3) begin
            s_d.halted = 1'b0;
        end
        // Read data and error are captured in the setup cycle.
        if (psel && !penable) begin
            s_d.err = 1'b0;
            if (is_mem) begin
                s_d.rdata = {24'h0, s_q.mem[bus_idx]};
            end else if (paddr == `REG_ACC_OFS) begin
                s_d.rdata = {24'h0, s_q.acc};
            end else if (paddr == `REG_FLAGS_OFS) begin
                s_d.rdata = {27'h0, s_q.flags};
            end else if (paddr == `REG_STATUS_OFS) begin
                s_d.rdata = {31'h0, s_q.halted};
            end else begin
                s_d.rdata = 32'h0;
                s_d.err = 1'b1;
            end
        end
        if (wr_access) begin
            if (is_mem) begin
                s_d.mem[bus_idx] = pwdata[7:0];
            end else if (paddr == `REG_ACC_OFS) begin
                s_d.acc = pwdata[7:0];
            end else if (paddr == `REG_FLAGS_OFS) begin
                s_d.flags = pwdata[`FLAG_WIDTH-1:0];
            end
        end
        if (take) begin
            s_d.done = 1'b1;
            if (alu.mem_we) begin
                s_d.mem[idx] = alu.result;
            end
            if (alu.acc_we) begin
                s_d.acc = alu.result;
            end
            if (alu.null_we) begin
                s_d.flags.result_null_flag = (alu.result == 8'h00);
            end
            if (alu.ovf_we) begin
                s_d.flags.overflow_out_bit = alu.ovf;
            end
            if (alu.halt) begin
                s_d.halted = 1'b1;
                s_d.wdt_clr = 1'b1;
                s_d.flags.power_down_flag = 1'b1;
                s_d.flags.timeout_flag = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.acc <= `ACC_RESET;
            s_q.flags <= `FLAGS_RESET;
            for (int i = 0; i < MEM_WORDS; i++) begin
                s_q.mem[i] <= `MEM_RESET;
            end
        end else begin
            s_q <= s_d;
        end
    end

    // Helper copy of the previous cycle's request and state, flagged by chk_v when taken, read only by assertions.
    logic chk_v;
    exec_op_t chk_op;
    logic [AW-1:0] chk_idx;
    logic [7:0] chk_acc;
    logic [7:0] chk_mem;
    flags_t chk_flags;
    logic chk_lo;
    logic chk_hi;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chk_v <= 1'b0;
            chk_op <= OP_BCD_ADJUST;
            chk_idx <= '0;
            chk_acc <= 8'h00;
            chk_mem <= 8'h00;
            chk_flags <= '0;
        end else begin
            chk_v <= take;
            chk_op <= exec_req.op;
            chk_idx <= idx;
            chk_acc <= s_q.acc;
            chk_mem <= s_q.mem[idx];
            chk_flags <= s_q.flags;
        end
    end

    assign chk_lo = (chk_acc[3:0] > 4'h9) || chk_flags.nibble_overflow_bit;
    assign chk_hi = (chk_acc[7:4] > 4'h9) || chk_flags.overflow_out_bit;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    AST_LOW_ADJUST: assert property (
        chk_v && chk_op == OP_BCD_ADJUST && chk_lo && !chk_hi
        |-> s_q.mem[chk_idx] == chk_acc + 8'h06)
        else $error("Low nibble adjust wrong.");

    AST_HIGH_ADJUST: assert property (
        chk_v && chk_op == OP_BCD_ADJUST && chk_hi && !chk_lo
        |-> s_q.mem[chk_idx] == chk_acc + 8'h60)
        else $error("High nibble adjust wrong.");

    AST_ADJUST_STORE: assert property (
        chk_v && chk_op == OP_BCD_ADJUST && !chk_hi
        |-> s_q.mem[chk_idx] == (chk_lo ? chk_acc + 8'h06 : chk_acc))
        else $error("Adjust result not stored.");

    AST_BOTH_ADJUST: assert property (
        chk_v && chk_op == OP_BCD_ADJUST && chk_hi && chk_lo
        |-> s_q.mem[chk_idx] == chk_acc + 8'h66)
        else $error("Both nibbles adjust wrong.");

    AST_ADJUST_FLAGS: assert property (
        chk_v && chk_op == OP_BCD_ADJUST
        |-> s_q.flags.overflow_out_bit == (chk_flags.overflow_out_bit | chk_hi)
            && s_q.flags[4:1] == chk_flags[4:1] && s_q.acc == chk_acc)
        else $error("Adjust flags wrong.");

    AST_DEC_STORE: assert property (
        chk_v && chk_op == OP_SUB_ONE_STORE
        |-> s_q.mem[chk_idx] == chk_mem - 8'h01
            && s_q.flags.result_null_flag == (chk_mem == 8'h01))
        else $error("Decrement store wrong.");

    AST_DEC_ACC: assert property (
        chk_v && chk_op == OP_SUB_ONE_TO_ACC
        |-> s_q.acc == chk_mem - 8'h01 && s_q.mem[chk_idx] == chk_mem
            && s_q.flags.result_null_flag == (chk_mem == 8'h01))
        else $error("Decrement to accumulator wrong.");

    AST_INC_STORE: assert property (
        chk_v && chk_op == OP_ADD_ONE_STORE
        |-> s_q.mem[chk_idx] == chk_mem + 8'h01
            && s_q.flags.result_null_flag == (chk_mem == 8'hff))
        else $error("Increment store wrong.");

    AST_INC_ACC: assert property (
        chk_v && chk_op == OP_ADD_ONE_TO_ACC
        |-> s_q.acc == chk_mem + 8'h01 && s_q.mem[chk_idx] == chk_mem)
        else $error("Increment to accumulator wrong.");

    AST_INC_ACC_NULL: assert property (
        chk_v && chk_op == OP_ADD_ONE_TO_ACC
        |-> s_q.flags.result_null_flag == (chk_mem == 8'hff))
        else $error("Null flag wrong after increment to accumulator.");

    AST_HALT_STOP: assert property (
        chk_v && chk_op == OP_POWER_DOWN
        |-> !clk_run && !exec_ready && s_q.acc == chk_acc)
        else $error("Power-down did not stop execution.");

    AST_HALT_KEEP: assert property (
        chk_v && chk_op == OP_POWER_DOWN
        |-> s_q.mem[chk_idx] == chk_mem)
        else $error("Power-down lost memory contents.");

    AST_WDT_PULSE: assert property (
        take && exec_req.op == OP_POWER_DOWN |=> wdt_clear ##1 !wdt_clear)
        else $error("Watchdog clear not a single pulse.");

    AST_HALT_FLAGS: assert property (
        chk_v && chk_op == OP_POWER_DOWN
        |-> s_q.flags.power_down_flag && !s_q.flags.timeout_flag
            && s_q.flags[2:0] == chk_flags[2:0])
        else $error("Power-down flags wrong.");

    AST_INVERT_ACC: assert property (
        chk_v && chk_op == OP_INVERT_TO_ACC
        |-> s_q.acc == ~chk_mem && s_q.mem[chk_idx] == chk_mem)
        else $error("Complement to accumulator wrong.");

    AST_NULL_FLAG: assert property (
        chk_v && chk_op == OP_INVERT_TO_ACC
        |-> s_q.flags.result_null_flag == (chk_mem == 8'hff))
        else $error("Null flag wrong after complement.");

    COV_BOTH_ADJUST: cover property (chk_v && chk_op == OP_BCD_ADJUST && chk_lo && chk_hi);
    COV_DEC_ZERO: cover property (chk_v && chk_op == OP_SUB_ONE_STORE && chk_mem == 8'h01);
    COV_HALT_WAKE: cover property (s_q.halted ##[1:50] !s_q.halted);
    COV_BUS_STALL: cover property (exec_valid && wr_access);
    COV_CARRY_SET: cover property (chk_v && chk_op == OP_BCD_ADJUST
        && !chk_flags.overflow_out_bit && s_q.flags.overflow_out_bit);

endmodule : bcd_adjust_incdec_halt_exec

`default_nettype wire

//--- dv/decoder_model.sv
/*
 * Behavioural instruction decoder that hands one operation at a time to
 * the execution block.
 * Assumes it shares sys_clk with the block and is called after a rising edge.
 */
`timescale 1ns/10ps
`default_nettype none
module decoder_model
    import bcd_exec_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Execution handshake
    input wire logic exec_ready,
    input wire logic exec_done,
    input wire logic wdt_clear,
    output logic exec_valid,
    output exec_req_t exec_req
);
    initial begin
        exec_valid = 1'b0;
        exec_req = '0;
    end

    // The request is held until an edge sees it taken or 50 edges pass; seen reports the cycle after.
    task automatic issue(input exec_op_t op, input logic [7:0] addr,
                         output logic [1:0] seen, output logic taken);
        int n;
        taken = 1'b0;
        n = 0;
        exec_valid <= 1'b1;
        exec_req <= '{op: op, addr: addr};
        while (!taken && n < 50) begin
            @(posedge sys_clk);
            taken = exec_ready;
            n++;
        end
        // Released lines show the inverse, so a stale value is never reused.
        exec_valid <= 1'b0;
        exec_req <= exec_req_t'(~{op, addr});
        @(posedge sys_clk);
        seen = {wdt_clear, exec_done};
    endtask : issue
endmodule : decoder_model
`default_nettype wire

//--- dv/tb.sv
/*
 * Self-checking bench for the execution block, one task per scenario.
 * Assumes the decoder model in dv/ and the design sources in src/.
 */
`timescale 1ns/10ps
`default_nettype none
`include "bcd_exec_params.svh"
module tb
    import bcd_exec_pkg::*;
;
    logic sys_clk, rst, psel, penable, pwrite, wake_pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, exec_valid, exec_ready, exec_done, clk_run, wdt_clear;
    exec_req_t exec_req;
    int mismatches = 0;
    int n_compared = 0;

    bcd_adjust_incdec_halt_exec #(.MEM_WORDS(16)) dut (
        .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .exec_valid(exec_valid),
        .exec_req(exec_req), .exec_ready(exec_ready), .exec_done(exec_done),
        .wake_pin(wake_pin), .clk_run(clk_run), .wdt_clear(wdt_clear)
    );

    decoder_model dec (
        .sys_clk(sys_clk), .rst(rst), .exec_ready(exec_ready),
        .exec_done(exec_done), .wdt_clear(wdt_clear),
        .exec_valid(exec_valid), .exec_req(exec_req)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        psel <= 1'b1;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for ready.
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // An idle cycle keeps the next setup from driving psel twice in one time step.
        @(posedge sys_clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp, "read data");
        chk({31'h0, e}, 32'h0, "mapped read refused");
    endtask : rd_chk

    function automatic logic [11:0] ma(input int i);
        return `MEM_BASE_OFS + 12'(4 * i);
    endfunction : ma

    task automatic run(input exec_op_t op, input logic [7:0] a, output logic [1:0] s);
        logic t;
        dec.issue(op, a, s, t);
        chk({31'h0, t & s[0]}, 32'h1, "request not taken or no done pulse");
    endtask : run

    task automatic t_reset_map;
        logic [31:0] d;
        logic e;
        rd_chk(`REG_ACC_OFS, 32'h0);
        rd_chk(`REG_FLAGS_OFS, 32'h0);
        rd_chk(`REG_STATUS_OFS, 32'h0);
        rd_chk(ma(0), 32'h0);
        apb(1'b0, 12'h03c, 32'h0, d, e);
        chk({31'h0, e}, 32'h1, "unmapped read not refused");
        chk(d, 32'h0, "unmapped read data");
        $display("reset and map test finished");
    endtask : t_reset_map

    task automatic t_bcd;
        logic [9:0] tc [7];
        logic [7:0] a, adj;
        logic lo, hi;
        logic [1:0] s;
        // Top two bits of each case are the nibble carry and the carry.
        tc = '{10'h045, 10'h04b, 10'h243, 10'h0a2, 10'h09a, 10'h112, 10'h0ab};
        for (int i = 0; i < 7; i++) begin
            a = tc[i][7:0];
            lo = a[3:0] > 4'h9 || tc[i][9];
            hi = a[7:4] > 4'h9 || tc[i][8];
            adj = (hi ? 8'h60 : 8'h00) | (lo ? 8'h06 : 8'h00);
            wr(`REG_ACC_OFS, {24'h0, a});
            wr(`REG_FLAGS_OFS, {27'h0, 3'b001, tc[i][9:8]});
            run(OP_BCD_ADJUST, 8'(i), s);
            rd_chk(ma(i), {24'h0, a + adj});
            rd_chk(`REG_ACC_OFS, {24'h0, a});
            rd_chk(`REG_FLAGS_OFS, {27'h0, 3'b001, tc[i][9], tc[i][8] | hi});
        end
        $display("bcd adjust test finished");
    endtask : t_bcd

    task automatic t_incdec;
        logic [7:0] vals [3];
        logic [7:0] v, r, m, ac;
        logic [1:0] s;
        vals = '{8'h00, 8'h01, 8'hff};
        for (int o = 1; o < 6; o++) begin
            for (int k = 0; k < 3; k++) begin
                v = vals[k];
                r = (o == 5) ? ~v : (o < 3) ? v - 8'h01 : v + 8'h01;
                m = (o == 1 || o == 3) ? r : v;
                ac = (o == 1 || o == 3) ? 8'h5a : r;
                wr(`REG_ACC_OFS, 32'h5a);
                wr(`REG_FLAGS_OFS, 32'h3);
                wr(ma(9), {24'h0, v});
                run(exec_op_t'(3'(o)), 8'h09, s);
                rd_chk(ma(9), {24'h0, m});
                rd_chk(`REG_ACC_OFS, {24'h0, ac});
                rd_chk(`REG_FLAGS_OFS, {29'h0, r == 8'h00, 2'b11});
            end
        end
        $display("increment and decrement test finished");
    endtask : t_incdec

    task automatic t_halt;
        logic [1:0] s;
        int n;
        wr(`REG_FLAGS_OFS, 32'h0d);
        wr(ma(2), 32'h3c);
        run(OP_POWER_DOWN, 8'h02, s);
        chk({31'h0, s[1]}, 32'h1, "watchdog clear pulse missing");
        chk({30'h0, clk_run, exec_ready}, 32'h0, "core still running");
        rd_chk(`REG_FLAGS_OFS, 32'h15);
        rd_chk(`REG_STATUS_OFS, 32'h1);
        rd_chk(ma(2), 32'h3c);
        wake_pin <= 1'b1;
        n = 0;
        while (exec_ready !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        chk({31'h0, clk_run}, 32'h1, "no wake from power down");
        wake_pin <= 1'b0;
        run(OP_ADD_ONE_STORE, 8'h02, s);
        rd_chk(ma(2), 32'h3d);
        $display("power down test finished");
    endtask : t_halt

    initial begin
        {psel, penable, pwrite, wake_pin} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        t_reset_map();
        t_bcd();
        t_incdec();
        t_halt();
        wrap_up();
    end

    // The scenarios need well under two thousand cycles.
    initial begin
        #100000;
        mismatches++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
